/* File: logic/kwd_pkg.sv */
// Package: register map, field layout and timing for the key wake detector
package kwd_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_KEY_LO    = 8'h00;  // match bytes 0-3
    localparam logic [7:0] OFF_KEY_HI    = 8'h04;  // match bytes 4-7
    localparam logic [7:0] OFF_CONTROL   = 8'h08;  // kbd_wake_control
    localparam logic [7:0] OFF_STATUS    = 8'h0C;  // wake status, W1C
    localparam logic [7:0] OFF_INFO      = 8'h10;  // last byte, state

    // ==========================================================
    // Control register fields
    localparam int MODE_LSB    = 0;   // detect_mode_sel, 2 bits
    localparam int SEQLEN_LSB  = 4;   // sequence_length_cfg, 4 bits
    localparam int PM1_LSB     = 8;   // pm_key1_length, 2 bits
    localparam int PM2_LSB     = 10;  // pm_key2_length, 2 bits
    localparam int PM3_LSB     = 12;  // pm_key3_length, 2 bits
    localparam int SWAP_BIT    = 16;  // swap keyboard/pointer lines
    localparam int KIRQ_EN_BIT = 17;  // keyboard irq enable
    localparam int MIRQ_EN_BIT = 18;  // pointer irq enable
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // ==========================================================
    // Status register bits
    localparam int ST_ANYK = 0;
    localparam int ST_EVT1 = 1;
    localparam int ST_EVT2 = 2;
    localparam int ST_EVT3 = 3;
    localparam int ST_KIRQ = 4;
    localparam int ST_MIRQ = 5;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        KWD_MODE_SEQ  = 2'b00,
        KWD_MODE_ANY  = 2'b01,
        KWD_MODE_PM   = 2'b10,
        KWD_MODE_OFF  = 2'b11
    } kwd_mode_t;

    localparam logic [3:0] PASSWORD_BIAS = 4'h7;
    localparam logic [7:0] BREAK_PREFIX  = 8'hF0;
    localparam logic [7:0] WILDCARD      = 8'h00;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SLOW_HZ         = 32_768;
    localparam int unsigned SLOW_DIV        = CLK_HZ / SLOW_HZ;
    localparam int unsigned KEY_GAP_S       = 4;
    localparam int unsigned KEY_GAP_TICKS   = KEY_GAP_S * SLOW_HZ;
    localparam real         VALID_DELAY_MS  = 32.0;
    localparam int unsigned VALID_DELAY_CYC =
        int'(VALID_DELAY_MS * 1.0e-3 * CLK_HZ);

    // ==========================================================
    // APB carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } kwd_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } kwd_apb_rsp_t;

    // Received byte with validity
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } kwd_byte_t;

endpackage

/* File: logic/kwd_rx.sv */
// Passive serial frame receiver for the keyboard line pair
module kwd_rx
    import kwd_pkg::*;
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Synchronised lines
    input  wire logic          line_clk,
    input  wire logic          line_dat,
    input  wire logic          enable,
    // Received byte
    output kwd_pkg::kwd_byte_t rx_byte
);
    import kwd_pkg::*;

    logic       clk_d;
    logic [3:0] bit_cnt;
    logic [9:0] shift;
    wire        fall = clk_d & ~line_clk;
    // Parity bit sits in shift[9] once the stop bit arrives
    wire        par_ok = ^{shift[9], shift[8:1]};
    wire        stop_ok = line_dat;

    // ==========================================================
    // Falling edge sampling, start/8 data/odd parity/stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d   <= 1'b1;
            bit_cnt <= 4'h0;
            shift   <= 10'h000;
            rx_byte <= '0;
        end else begin
            clk_d         <= line_clk;
            rx_byte.valid <= 1'b0;
            if (!enable) begin
                bit_cnt <= 4'h0;
            end else if (fall) begin
                if (bit_cnt == 4'h0) begin
                    if (!line_dat) begin
                        bit_cnt <= 4'h1;
                    end
                end else if (bit_cnt == 4'hA) begin
                    bit_cnt <= 4'h0;
                    if (par_ok && stop_ok) begin
                        rx_byte.valid <= 1'b1;
                        rx_byte.data  <= shift[8:1];
                    end
                end else begin
                    shift   <= {line_dat, shift[9:1]};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
        end
    end

endmodule

/* File: logic/kwd_timer.sv */
// Slow tick divider and key gap timer
module kwd_timer
    import kwd_pkg::*;
#(
    parameter int unsigned DIV   = SLOW_DIV,
    parameter int unsigned TICKS = KEY_GAP_TICKS
)
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic restart,
    // Status
    output logic      expired
);
    import kwd_pkg::*;

    logic [15:0] div_cnt;
    logic [17:0] gap_cnt;
    wire         tick = (div_cnt == 16'(DIV - 1));

    // ==========================================================
    // 32 kHz enable and 4 s counter, restarted per byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            gap_cnt <= 18'h00000;
            expired <= 1'b1;
        end else begin
            div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
            if (restart) begin
                gap_cnt <= 18'h00000;
                expired <= 1'b0;
            end else if (tick && !expired) begin
                if (gap_cnt == 18'(TICKS - 1)) begin
                    expired <= 1'b1;
                end else begin
                    gap_cnt <= gap_cnt + 18'h00001;
                end
            end
        end
    end

endmodule

/* File: logic/kwd_top.sv */
// Keyboard wake sequence detector with APB register access
module kwd_top
    import kwd_pkg::*;
#(
    parameter int unsigned VALID_CYC = VALID_DELAY_CYC,
    parameter int unsigned GAP_TICKS = KEY_GAP_TICKS,
    parameter int unsigned TICK_DIV  = SLOW_DIV
)
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial lines, sensed only
    input  wire logic        kbd_serial_clock,
    input  wire logic        kbd_serial_data,
    input  wire logic        pointer_serial_clock,
    input  wire logic        pointer_serial_data,
    // Keyboard controller interrupts
    input  wire logic        kbd_irq,
    input  wire logic        pointer_irq,
    // Flags out
    output logic [5:0]       wake_status
);
    import kwd_pkg::*;

    // ==========================================================
    // Input synchronisers
    logic [3:0] lines_s1;
    logic [3:0] lines_s2;
    logic [1:0] irq_s1;
    logic [1:0] irq_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lines_s1 <= 4'hF;
            lines_s2 <= 4'hF;
            irq_s1   <= 2'h0;
            irq_s2   <= 2'h0;
        end else begin
            lines_s1 <= {kbd_serial_clock, kbd_serial_data,
                         pointer_serial_clock, pointer_serial_data};
            lines_s2 <= lines_s1;
            irq_s1   <= {pointer_irq, kbd_irq};
            irq_s2   <= irq_s1;
        end
    end

    // ==========================================================
    // Registers
    kwd_apb_req_t req;
    logic [7:0]  key_match_bytes [8];
    logic [31:0] kbd_wake_control;
    logic [5:0]  status;
    logic [23:0] valid_cnt;
    logic        inputs_valid;
    logic [1:0]  seq_pos;
    logic [3:0]  match_idx;
    logic [1:0]  pm_idx [3];
    logic        after_break;
    logic        in_recovery;
    logic [7:0]  last_byte;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};

    wire kwd_mode_t detect_mode_sel =
        kwd_mode_t'(kbd_wake_control[MODE_LSB +: 2]);
    wire [3:0] sequence_length_cfg = kbd_wake_control[SEQLEN_LSB +: 4];
    wire [1:0] pm_key1_length = kbd_wake_control[PM1_LSB +: 2];
    wire [1:0] pm_key2_length = kbd_wake_control[PM2_LSB +: 2];
    wire [1:0] pm_key3_length = kbd_wake_control[PM3_LSB +: 2];
    wire       swap_lines     = kbd_wake_control[SWAP_BIT];

    // ==========================================================
    // Line swap and receiver
    wire kb_clk = swap_lines ? lines_s2[1] : lines_s2[3];
    wire kb_dat = swap_lines ? lines_s2[0] : lines_s2[2];
    kwd_byte_t rx;

    // Pointer lines reach this receiver when swap_lines is set; there is no other pointer path
    kwd_rx u_rx (
        .pclk     (pclk),
        .presetn  (presetn),
        .line_clk (kb_clk),
        .line_dat (kb_dat),
        .enable   (inputs_valid),
        .rx_byte  (rx)
    );

    logic gap_expired;
    kwd_timer #(.DIV(TICK_DIV), .TICKS(GAP_TICKS)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (rx.valid),
        .expired (gap_expired)
    );

    // ==========================================================
    // Matching helpers
    function automatic logic byte_hit(input logic [7:0] want,
                                      input logic [7:0] got);
        byte_hit = (want == WILDCARD) || (want == got);
    endfunction

    wire        is_password = (sequence_length_cfg >= 4'h8);
    // Bytes (or keys) in the sequence, 1..8
    wire [3:0]  seq_total   = is_password ?
        4'(sequence_length_cfg - PASSWORD_BIAS)
        : 4'(sequence_length_cfg + 4'h1);
    wire        seq_len_ok  = (seq_total != 4'h0) && (seq_total <= 4'h8);
    // A gap of 4 s between bytes restarts the sequence
    wire        fresh       = gap_expired;
    wire [3:0]  cur_idx     = fresh ? 4'h0 : match_idx;
    wire        brk         = (rx.data == BREAK_PREFIX);
    // Password: drop release prefix and the byte after it
    wire        skip_byte   = is_password && (brk || after_break);
    wire        seq_hit     = byte_hit(key_match_bytes[cur_idx[2:0]],
                                       rx.data);
    wire        seq_done    = seq_hit && (cur_idx + 4'h1 == seq_total);

    // Power-management groups
    wire [1:0]  pm_len  [3];
    wire [3:0]  pm_base [3];
    wire [2:0]  pm_hit;
    wire [2:0]  pm_done;
    assign pm_len[0]  = pm_key1_length;
    assign pm_len[1]  = pm_key2_length;
    assign pm_len[2]  = pm_key3_length;
    assign pm_base[0] = 4'h0;
    assign pm_base[1] = 4'h3;
    assign pm_base[2] = 4'h6;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pm
            wire [1:0] idx = fresh ? 2'h0 : pm_idx[g];
            wire [3:0] addr = 4'(pm_base[g] + {2'h0, idx});
            // Group three has only two bytes
            wire [1:0] lim = (g == 2 && pm_len[g] == 2'h3) ?
                             2'h2 : pm_len[g];
            assign pm_hit[g]  = (lim != 2'h0) &&
                byte_hit(key_match_bytes[addr[2:0]], rx.data);
            assign pm_done[g] = pm_hit[g] && (idx + 2'h1 == lim);
        end
    endgenerate

    // ==========================================================
    // Detection state
    wire byte_ok = rx.valid && inputs_valid && !(in_recovery && !fresh);
    wire [3:0] set_evt;
    assign set_evt[ST_ANYK] = byte_ok && detect_mode_sel == KWD_MODE_ANY;
    assign set_evt[ST_EVT1] = byte_ok && (
        (detect_mode_sel == KWD_MODE_SEQ && !skip_byte && seq_len_ok &&
         seq_done) ||
        (detect_mode_sel == KWD_MODE_PM && pm_done[0]));
    assign set_evt[ST_EVT2] = byte_ok && detect_mode_sel == KWD_MODE_PM &&
                              pm_done[1];
    assign set_evt[ST_EVT3] = byte_ok && detect_mode_sel == KWD_MODE_PM &&
                              pm_done[2];
    wire seq_miss = detect_mode_sel == KWD_MODE_SEQ && !skip_byte &&
                    !seq_hit;
    wire pm_miss  = detect_mode_sel == KWD_MODE_PM && pm_hit == 3'h0;
    wire wrong    = byte_ok && (seq_miss || pm_miss);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_idx   <= 4'h0;
            pm_idx      <= '{default: 2'h0};
            after_break <= 1'b0;
            in_recovery <= 1'b0;
            last_byte   <= 8'h00;
        end else if (rx.valid) begin
            last_byte   <= rx.data;
            after_break <= brk;
            if (in_recovery && !fresh) begin
                in_recovery <= 1'b1;
            end else if (wrong) begin
                in_recovery <= 1'b1;
                match_idx   <= 4'h0;
                pm_idx      <= '{default: 2'h0};
            end else begin
                in_recovery <= 1'b0;
                if (!skip_byte) begin
                    match_idx <= seq_done ? 4'h0 : cur_idx + 4'h1;
                end
                // Any group finishing ends all, so a prefix wins
                for (int k = 0; k < 3; k++) begin
                    if (pm_done != 3'h0 || !pm_hit[k]) begin
                        pm_idx[k] <= 2'h0;
                    end else begin
                        pm_idx[k] <= (fresh ? 2'h0 : pm_idx[k]) + 2'h1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Power-up input-valid delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_cnt    <= 24'h000000;
            inputs_valid <= 1'b0;
        end else if (!inputs_valid) begin
            valid_cnt    <= valid_cnt + 24'h000001;
            inputs_valid <= (valid_cnt == 24'(VALID_CYC - 1));
        end
    end

    // ==========================================================
    // APB decode
    wire       access = req.psel && req.penable;
    wire       wr     = access && req.pwrite && !pready;
    wire       hit_lo = req.paddr == OFF_KEY_LO;
    wire       hit_hi = req.paddr == OFF_KEY_HI;
    wire       hit_ct = req.paddr == OFF_CONTROL;
    wire       hit_st = req.paddr == OFF_STATUS;
    wire       hit_in = req.paddr == OFF_INFO;
    wire       mapped = hit_lo | hit_hi | hit_ct | hit_st | hit_in;
    wire [5:0] w1c    = (wr && hit_st) ? req.pwdata[5:0] : 6'h00;
    wire [1:0] irq_on = irq_s2 & {kbd_wake_control[MIRQ_EN_BIT],
                                  kbd_wake_control[KIRQ_EN_BIT]};
    wire [5:0] set_all = {irq_on, set_evt};
    wire [5:0] next_status = (status & ~w1c) | set_all;
    wire [31:0] rd_mux =
        hit_lo ? {key_match_bytes[3], key_match_bytes[2],
                  key_match_bytes[1], key_match_bytes[0]} :
        hit_hi ? {key_match_bytes[7], key_match_bytes[6],
                  key_match_bytes[5], key_match_bytes[4]} :
        hit_ct ? kbd_wake_control :
        hit_st ? {26'h0, status} :
        hit_in ? {18'h0, inputs_valid, in_recovery, match_idx,
                  last_byte} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kbd_wake_control <= CONTROL_RESET;
            key_match_bytes  <= '{default: 8'h00};
            status           <= 6'h00;
            wake_status      <= 6'h00;
            prdata           <= 32'h0000_0000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
        end else begin
            status      <= next_status;
            wake_status <= next_status;
            // Answer in the second access cycle
            pready  <= req.psel && req.penable && !pready;
            pslverr <= req.psel && req.penable && !pready && !mapped;
            prdata  <= rd_mux;
            if (wr && !pready) begin
                if (hit_ct) begin
                    kbd_wake_control <= req.pwdata;
                end
                for (int k = 0; k < 4; k++) begin
                    if (hit_lo) key_match_bytes[k] <= req.pwdata[8*k +: 8];
                    if (hit_hi) key_match_bytes[k+4] <= req.pwdata[8*k +: 8];
                end
            end
        end
    end

endmodule

/* File: test/kwd_kbd_model.sv */
// Keyboard model: one serial frame per request on the line pair
module kwd_kbd_model
(
    // Clock
    input  wire logic       pclk,
    // Request
    input  wire logic       send,
    input  wire logic [7:0] code,
    output logic            busy,
    // Serial lines, driven high when idle
    output logic            ser_clk,
    output logic            ser_dat
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] frame;
    initial begin
        busy = 1'b0;
        ser_clk = 1'b1;
        ser_dat = 1'b1;
    end
    // ==========================================================
    // Frame: start, data LSB first, odd parity, stop
    always begin
        @(posedge pclk iff send);
        busy = 1'b1;
        frame = {1'b1, ~^code, code, 1'b0};
        for (int i = 0; i < 11; i++) begin
            ser_dat = frame[i];
            #40 ser_clk = 1'b0;
            #80 ser_clk = 1'b1;
            #40;
        end
        ser_dat = 1'b1;
        busy = 1'b0;
    end
endmodule

/* File: test/kwd_checker.sv */
// Checker: bus and status properties of the key wake detector
module kwd_checker
    import kwd_pkg::*;
#(
    parameter int unsigned VALID_CYC = 20
)
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupts and flags
    input wire logic        kbd_irq,
    input wire logic        pointer_irq,
    input wire logic [5:0]  wake_status
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] ctl;
    logic [31:0] age;
    wire         wr_st = psel && penable && pwrite && paddr == OFF_STATUS;
    wire         wr_ct = psel && penable && pready && pwrite
                         && paddr == OFF_CONTROL;
    // ==========================================================
    // Shadow of control and cycles since reset, held at VALID_CYC
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= CONTROL_RESET;
            age <= 32'h0;
        end else begin
            if (wr_ct)
                ctl <= pwdata;
            if (age < VALID_CYC)
                age <= age + 32'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Properties
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready |->
        pslverr == (paddr > OFF_INFO || paddr[1:0] != 2'b00))
        else $error("error response does not match address");
    a_no_early: assert property (
        age < VALID_CYC |-> wake_status[3:0] == 4'h0)
        else $error("key event inside input-valid delay");
    a_flag_sticky: assert property (
        ($past(wake_status[3:0]) & ~wake_status[3:0]) != 4'h0
        |-> $past(wr_st) || $past(wr_st, 2))
        else $error("key flag fell without a clear write");
    a_anyk_mode: assert property (
        $rose(wake_status[ST_ANYK]) |-> ctl[1:0] == KWD_MODE_ANY)
        else $error("any-key flag outside any-key mode");
    a_pm_mode: assert property (
        $rose(wake_status[ST_EVT2] || wake_status[ST_EVT3])
        |-> ctl[1:0] == KWD_MODE_PM)
        else $error("event 2 or 3 outside power key mode");
    a_kirq_set: assert property (
        (kbd_irq && ctl[KIRQ_EN_BIT]) [*6] |-> wake_status[ST_KIRQ])
        else $error("held keyboard irq not flagged");
    a_mirq_set: assert property (
        (pointer_irq && ctl[MIRQ_EN_BIT]) [*6] |-> wake_status[ST_MIRQ])
        else $error("held pointer irq not flagged");
    a_kirq_gate: assert property (
        $rose(wake_status[ST_KIRQ]) |-> ctl[KIRQ_EN_BIT]
        || $past(ctl[KIRQ_EN_BIT]) || $past(ctl[KIRQ_EN_BIT], 2))
        else $error("keyboard irq flagged while disabled");
endmodule

bind kwd_top kwd_checker #(.VALID_CYC(VALID_CYC)) u_kwd_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .kbd_irq(kbd_irq),
    .pointer_irq(pointer_irq), .wake_status(wake_status));

/* File: test/kwd_top_test.sv */
// Testbench: scenarios for the key wake detector
module kwd_top_test;
    import kwd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        kbd_irq = 1'b0;
    logic        pointer_irq = 1'b0;
    logic [5:0]  wake_status;
    logic        send = 1'b0;
    logic [7:0]  code = 8'h00;
    logic        busy;
    logic        m_clk;
    logic        m_dat;
    logic        swap_sel = 1'b0;
    int          fail_count = 0;
    int          n_tests = 0;
    always #10 pclk = ~pclk;
    kwd_top #(.VALID_CYC(20), .GAP_TICKS(64), .TICK_DIV(4)) u_kwd_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .kbd_serial_clock(swap_sel ? 1'b1 : m_clk),
        .kbd_serial_data(swap_sel ? 1'b1 : m_dat),
        .pointer_serial_clock(swap_sel ? m_clk : 1'b1),
        .pointer_serial_data(swap_sel ? m_dat : 1'b1),
        .kbd_irq(kbd_irq), .pointer_irq(pointer_irq),
        .wake_status(wake_status));
    kwd_kbd_model u_kwd_kbd_model (.pclk(pclk), .send(send), .code(code),
        .busy(busy), .ser_clk(m_clk), .ser_dat(m_dat));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, x);
    endtask
    task automatic st(input logic [5:0] x);
        repeat (6) @(posedge pclk);
        rd(OFF_STATUS, {26'h0, x});
        check({26'h0, wake_status}, {26'h0, x});
    endtask
    task automatic clr();
        wr(OFF_STATUS, 32'h3F);
        repeat (400) @(posedge pclk);
    endtask
    task automatic keys(input logic [7:0] s[$]);
        foreach (s[i]) begin
            @(posedge pclk);
            send <= 1'b1;
            code <= s[i];
            @(posedge pclk);
            send <= 1'b0;
            do begin
                @(posedge pclk);
            end while (busy);
            repeat (10) @(posedge pclk);
        end
    endtask
    function automatic logic [31:0] cfg(input logic [1:0] m,
        input logic [3:0] n, input logic [1:0] a, b, c);
        return (32'(m) << MODE_LSB) | (32'(n) << SEQLEN_LSB)
            | (32'(a) << PM1_LSB) | (32'(b) << PM2_LSB) | (32'(c) << PM3_LSB);
    endfunction
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        rd(OFF_CONTROL, CONTROL_RESET);
        wr(OFF_CONTROL, 32'h0007_2FF3);
        rd(OFF_CONTROL, 32'h0007_2FF3);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF, q, e);
        check({31'h0, e}, 32'h1);
        apb(1'b0, 8'h20, 32'h0, q, e);
        check(q, 32'h0);
    endtask
    task automatic t_anykey();
        wr(OFF_CONTROL, cfg(KWD_MODE_ANY, 4'h0, 2'h0, 2'h0, 2'h0));
        clr();
        keys({8'h1C});
        st(6'h01);
        wr(OFF_STATUS, 32'h0);
        st(6'h01);
        clr();
        st(6'h00);
    endtask
    task automatic t_seq();
        wr(OFF_KEY_LO, 32'h0403_0201);
        wr(OFF_KEY_HI, 32'h0807_0605);
        wr(OFF_CONTROL, cfg(KWD_MODE_SEQ, 4'd15, 2'h0, 2'h0, 2'h0));
        clr();
        keys({8'h01, 8'h02, 8'hF0, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
        keys({8'h07, 8'h08});
        st(6'h02);
        clr();
        wr(OFF_KEY_LO, 32'hDBE0_5BE0);
        wr(OFF_CONTROL, cfg(KWD_MODE_SEQ, 4'd3, 2'h0, 2'h0, 2'h0));
        keys({8'hE0, 8'h5B, 8'hE0});
        st(6'h00);
        keys({8'hDB});
        st(6'h02);
        clr();
        keys({8'hE0, 8'h5B});
        repeat (400) @(posedge pclk);
        keys({8'hE0, 8'hDB});
        st(6'h00);
        clr();
        keys({8'h11, 8'hE0, 8'h5B, 8'hE0, 8'hDB});
        st(6'h00);
        clr();
        keys({8'hE0, 8'h5B, 8'hE0, 8'hDB});
        st(6'h02);
        clr();
        wr(OFF_KEY_LO, 32'h0);
        wr(OFF_CONTROL, cfg(KWD_MODE_SEQ, 4'd1, 2'h0, 2'h0, 2'h0));
        keys({8'h1C, 8'hF0});
        st(6'h02);
        clr();
    endtask
    task automatic t_pm();
        wr(OFF_KEY_LO, 32'h1133_2211);
        wr(OFF_KEY_HI, 32'h6655_4422);
        wr(OFF_CONTROL, cfg(KWD_MODE_PM, 4'h0, 2'd3, 2'd3, 2'd2));
        clr();
        keys({8'h11, 8'h22, 8'h44});
        st(6'h04);
        clr();
        keys({8'h55, 8'h66});
        st(6'h08);
        clr();
        keys({8'h11, 8'h22, 8'h33});
        st(6'h02);
        clr();
        wr(OFF_CONTROL, cfg(KWD_MODE_PM, 4'h0, 2'd2, 2'd3, 2'd2));
        keys({8'h11, 8'h22, 8'h44});
        st(6'h02);
        clr();
    endtask
    task automatic t_irq();
        wr(OFF_CONTROL, 32'h1 << KIRQ_EN_BIT);
        kbd_irq <= 1'b1;
        pointer_irq <= 1'b1;
        st(6'h10);
        wr(OFF_STATUS, 32'h3F);
        st(6'h10);
        kbd_irq <= 1'b0;
        pointer_irq <= 1'b0;
        clr();
        st(6'h00);
        wr(OFF_CONTROL, 32'h1 << MIRQ_EN_BIT);
        pointer_irq <= 1'b1;
        repeat (8) @(posedge pclk);
        pointer_irq <= 1'b0;
        st(6'h20);
        clr();
    endtask
    task automatic t_swap();
        wr(OFF_CONTROL, cfg(KWD_MODE_ANY, 4'h0, 2'h0, 2'h0, 2'h0)
            | (32'h1 << SWAP_BIT));
        swap_sel <= 1'b1;
        keys({8'h1C});
        st(6'h01);
        clr();
        swap_sel <= 1'b0;
        keys({8'h1C});
        st(6'h00);
    endtask
    task automatic conclude();
        $display("checks=%0d failures=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_anykey();
        t_seq();
        t_pm();
        t_irq();
        t_swap();
        conclude();
    end
    initial begin
        #(40000 * 20);
        fail_count++;
        conclude();
    end
endmodule
